// ---- hdl/pba_dev.sv ----
// buffer manager: shared page pool, packet numbers, three packet queues,
// completion status store and the queue based interrupt flags.
// assumes the host drives the link from the same clock and the network
// engine on the plain ports keeps one request open at a time.
//
// How it works
// [RL1] one shared page pool, no fixed split
// [RL2] only writers allocate: host tx, engine rx
// [RL3] rx allocation fails below transmit reserve; the code also refuses it when free pages equal the reserve
// [RL4] rx accepted again once free exceeds reserve
// [RL5] zero reserve gives plain first-come allocation
// [RL6] free pages and pool size readable
// [RL7] reserve changeable live, running receptions finish
// [RL8] results stored per packet, no register wait
// [RL9] rx interrupt while rx queue non-empty, enabled
// [RL10] tx done flag while completion queue non-empty
// [RL11] tx empty flag while transmit queue empty
// [RL12] auto-free releases good transmits, skips completion
// [RL13] completions returned in finishing order
// [RL14] per-packet mode: done irq, no auto-free
// [RL15] per-sequence mode: both irqs, auto-free on
// [RL16] fatal error under auto-free sets done flag
// [RL17] interrupting code saves and restores pointer
// [RL18] interrupting code saves packet select too
// [RL19] allocation done cleared on new request; a host grant landing in the same cycle sets it instead
// [RL20] numbers central, reused only after release
// [RL21] tx failure raises done, clears transmit enable
// [RL22] free count follows every allocation and release
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
module pba_dev (
	input  wire logic                clk_sys_i,         // system clock
	input  wire logic                resetn_i,          // async reset, low
	pba_if.dev                       link,              // host side
	input  wire logic                rx_alloc_req_i,    // engine wants a packet
	input  wire pba_pkg::pba_pages_t rx_alloc_pages_i,  // pages it needs
	output logic                     rx_alloc_ack_o,    // one-cycle answer
	output logic                     rx_alloc_ok_o,     // answer was a grant
	output pba_pkg::pba_pnum_t       rx_alloc_pnum_o,   // granted number
	input  wire logic                rx_done_i,         // end of reception
	input  wire logic                rx_good_i,         // frame kept
	input  wire pba_pkg::pba_pnum_t  rx_pnum_i,         // packet it filled
	input  wire pba_pkg::pba_stat_t  rx_status_i,       // receive status word
	output logic                     tx_req_o,          // packet ready to send
	output pba_pkg::pba_pnum_t       tx_pnum_o,         // packet to send
	input  wire logic                tx_done_i,         // transmission finished
	input  wire logic                tx_ok_i,           // it succeeded
	input  wire pba_pkg::pba_stat_t  tx_status_i        // transmit status word
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [`PBA_NUM_PKT-1:0] in_use;                  // number owned by someone
	pba_pkg::pba_pages_t     pages_of [`PBA_NUM_PKT]; // pages behind each number
	pba_pkg::pba_stat_t      status_of [`PBA_NUM_PKT];// result word per number
	pba_pkg::pba_pages_t     free_pages;              // pages still in the pool
	logic                    alloc_pend;              // host allocation waiting
	pba_pkg::pba_pages_t     alloc_pages;             // its size
	pba_pkg::pba_pnum_t      alloc_pnum;              // last host grant
	logic                    alloc_done;              // allocation_done_irq flag
	logic                    tx_enable;               // transmit_enable_bit
	logic [`PBA_NQ-1:0]      q_push;                  // queue writes
	logic [`PBA_NQ-1:0]      q_pop;                   // queue reads
	logic [`PBA_NQ-1:0]      q_empty;                 // queue empty
	pba_pkg::pba_pnum_t      q_din [`PBA_NQ];         // value written
	pba_pkg::pba_pnum_t      q_head [`PBA_NQ];        // oldest entry

	////////////////////////////////////////////////////////////////////////////
	// command decode
	wire cmd_alloc = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_ALLOC);
	wire cmd_enq   = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_ENQ);
	wire cmd_rel   = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_REL);
	wire cmd_rxpop = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_RXPOP);
	wire cmd_txack = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_TXACK);
	wire cmd_txen  = link.cmd_valid && (link.cmd_code == pba_pkg::PBA_TXEN);
	wire tx_fail   = tx_done_i && !tx_ok_i;
	wire tx_auto   = tx_done_i && tx_ok_i && link.auto_free;

	////////////////////////////////////////////////////////////////////////////
	// lowest unused packet number
	logic               lo_valid;  // some number is free
	pba_pkg::pba_pnum_t lo_pnum;   // lowest free number
	always_comb begin
		lo_valid = 1'b0;
		lo_pnum  = '0;
		for (int n = `PBA_NUM_PKT - 1; n >= 0; n--) begin
			if (!in_use[n]) begin
				lo_valid = 1'b1;
				lo_pnum  = pba_pkg::pba_pnum_t'(n);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// allocation arbitration; the engine wins a tie because a frame on the
	// wire cannot wait, the host request just stays pending one more cycle
	wire rx_try    = rx_alloc_req_i && !rx_alloc_ack_o;                 // [RL2]
	wire rx_room   = free_pages > link.reserve;                         // [RL3] [RL4] [RL7]
	wire rx_fits   = lo_valid && rx_room && (free_pages >= rx_alloc_pages_i); // [RL5]
	wire rx_grant  = rx_try && rx_fits;
	wire host_try  = alloc_pend && !rx_try;                             // [RL2]
	wire host_fits = lo_valid && (free_pages >= alloc_pages);           // [RL1]
	wire host_grant = host_try && host_fits;
	wire any_grant = rx_grant || host_grant;
	wire [`PBA_PAGE_W-1:0] grant_pages = rx_grant ? rx_alloc_pages_i : alloc_pages;

	////////////////////////////////////////////////////////////////////////////
	// releases from all sources may land in one cycle, so they are a vector
	logic [`PBA_NUM_PKT-1:0] rel_vec;   // numbers released this cycle
	logic [`PBA_NUM_PKT-1:0] alloc_vec; // number granted this cycle
	pba_pkg::pba_pages_t     rel_sum;   // pages coming back
	always_comb begin
		rel_sum = '0;
		for (int n = 0; n < `PBA_NUM_PKT; n++) begin
			if (rel_vec[n]) begin
				rel_sum = pba_pkg::pba_pages_t'(rel_sum + pages_of[n]);
			end
		end
	end

	// next free count: minus the grant, plus everything released
	wire [`PBA_PAGE_W-1:0] next_free = pba_pkg::pba_pages_t'(free_pages
		- (any_grant ? grant_pages : 8'h00) + rel_sum);

	////////////////////////////////////////////////////////////////////////////
	// per packet number bookkeeping
	genvar n;
	generate
		for (n = 0; n < `PBA_NUM_PKT; n++) begin : g_pkt
			assign alloc_vec[n] = any_grant && (lo_pnum == n);
			assign rel_vec[n] = in_use[n] && (
				(cmd_rel && link.pkt_sel == n) ||
				(cmd_rxpop && !q_empty[`PBA_Q_RX] && q_head[`PBA_Q_RX] == n) ||
				(rx_done_i && !rx_good_i && rx_pnum_i == n) ||
				(tx_auto && q_head[`PBA_Q_TX] == n));           // [RL12]
			// ownership, size and stored result of this number
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					in_use[n]    <= 1'b0;
					pages_of[n]  <= '0;
					status_of[n] <= '0;
				end else begin
					in_use[n] <= (in_use[n] && !rel_vec[n]) || alloc_vec[n]; // [RL20]
					if (alloc_vec[n]) begin
						pages_of[n] <= grant_pages;
					end
					if (tx_done_i && q_head[`PBA_Q_TX] == n) begin
						status_of[n] <= tx_status_i;                // [RL8]
					end else if (rx_done_i && rx_pnum_i == n) begin
						status_of[n] <= rx_status_i;                // [RL8]
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// queues: each is deep enough for every number, so no full check
	assign q_push[`PBA_Q_TX]   = cmd_enq;
	assign q_din[`PBA_Q_TX]    = link.pkt_sel;
	assign q_pop[`PBA_Q_TX]    = tx_done_i && !q_empty[`PBA_Q_TX];
	assign q_push[`PBA_Q_DONE] = tx_done_i && !tx_auto;        // [RL12] [RL16] [RL21]
	assign q_din[`PBA_Q_DONE]  = q_head[`PBA_Q_TX];            // [RL13]
	assign q_pop[`PBA_Q_DONE]  = cmd_txack && !q_empty[`PBA_Q_DONE];
	assign q_push[`PBA_Q_RX]   = rx_done_i && rx_good_i;
	assign q_din[`PBA_Q_RX]    = rx_pnum_i;
	assign q_pop[`PBA_Q_RX]    = cmd_rxpop && !q_empty[`PBA_Q_RX];

	genvar q;
	generate
		for (q = 0; q < `PBA_NQ; q++) begin : g_q
			pba_pkg::pba_pnum_t     mem [`PBA_NUM_PKT]; // queue storage
			logic [`PBA_PNUM_W:0]   wr_ptr;             // write index, extra wrap bit
			logic [`PBA_PNUM_W:0]   rd_ptr;             // read index
			assign q_empty[q] = (wr_ptr == rd_ptr);
			assign q_head[q]  = mem[rd_ptr[`PBA_PNUM_W-1:0]];
			// pointers move on their own strobes
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					wr_ptr <= '0;
					rd_ptr <= '0;
				end else begin
					if (q_push[q]) begin
						wr_ptr <= wr_ptr + 1'b1;
					end
					if (q_pop[q]) begin
						rd_ptr <= rd_ptr + 1'b1;
					end
				end
			end
			// storage has no reset; only entries behind wr_ptr are read
			always_ff @(posedge clk_sys_i) begin
				if (q_push[q]) begin
					mem[wr_ptr[`PBA_PNUM_W-1:0]] <= q_din[q];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// pool count, host allocation and transmit enable
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			free_pages  <= `PBA_MEM_PAGES;
			alloc_pend  <= 1'b0;
			alloc_pages <= '0;
			alloc_pnum  <= '0;
			alloc_done  <= 1'b0;
			tx_enable   <= 1'b0;
		end else begin
			free_pages <= next_free;                                    // [RL22]
			if (cmd_alloc) begin
				alloc_pend  <= 1'b1;
				alloc_pages <= link.cmd_arg;
			end else if (host_grant) begin
				alloc_pend <= 1'b0;
			end
			if (host_grant) begin
				alloc_pnum <= lo_pnum;
			end
			// a grant in the cycle of a new request still shows
			if (host_grant) begin
				alloc_done <= 1'b1;
			end else if (cmd_alloc) begin
				alloc_done <= 1'b0;                                     // [RL19]
			end
			// a failure stops the sequence even against a re-enable
			if (tx_fail) begin
				tx_enable <= 1'b0;                                      // [RL21]
			end else if (cmd_txen) begin
				tx_enable <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// engine answer, registered so it stands one clean cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_alloc_ack_o  <= 1'b0;
			rx_alloc_ok_o   <= 1'b0;
			rx_alloc_pnum_o <= '0;
		end else begin
			rx_alloc_ack_o <= rx_try;
			rx_alloc_ok_o  <= rx_grant;                                 // [RL3]
			if (rx_grant) begin
				rx_alloc_pnum_o <= lo_pnum;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign tx_req_o  = tx_enable && !q_empty[`PBA_Q_TX];
	assign tx_pnum_o = q_head[`PBA_Q_TX];

	wire [3:0] flags = {alloc_done,
		q_empty[`PBA_Q_TX],                                              // [RL11]
		!q_empty[`PBA_Q_DONE],                                           // [RL10] [RL16]
		!q_empty[`PBA_Q_RX]};
	assign link.flags         = flags;
	assign link.irq           = |(flags & link.irq_mask);              // [RL9]
	assign link.alloc_pending = alloc_pend;
	assign link.alloc_pnum    = alloc_pnum;
	assign link.free_pages    = free_pages;                            // [RL6]
	assign link.total_pages   = `PBA_MEM_PAGES;                        // [RL6]
	assign link.tx_enable     = tx_enable;
	assign link.rx_head       = q_head[`PBA_Q_RX];
	assign link.done_head     = q_head[`PBA_Q_DONE];                   // [RL13]
	assign link.pkt_status    = status_of[link.pkt_sel];               // [RL8]

endmodule
`default_nettype wire

// ---- hdl/pba_consts.svh ----
// constants of the packet buffer allocator: sizes, command codes, queue and
// flag positions, register offsets and reset values.
// assumes nothing; included by the package and by both ends.
`ifndef PBA_CONSTS_SVH
`define PBA_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// pool shape
`define PBA_NUM_PKT     16
`define PBA_PNUM_W      4
`define PBA_PAGE_W      8
`define PBA_MEM_PAGES   8'h18
`define PBA_STAT_W      16
`define PBA_PTR_W       11

////////////////////////////////////////////////////////////////////////////////
// command codes on the link
`define PBA_CMD_NOP     3'h0
`define PBA_CMD_ALLOC   3'h1
`define PBA_CMD_ENQ     3'h2
`define PBA_CMD_REL     3'h3
`define PBA_CMD_RXPOP   3'h4
`define PBA_CMD_TXACK   3'h5
`define PBA_CMD_TXEN    3'h6

////////////////////////////////////////////////////////////////////////////////
// queue indices and flag bits
`define PBA_NQ          3
`define PBA_Q_TX        0
`define PBA_Q_DONE      1
`define PBA_Q_RX        2
`define PBA_FL_RX       0
`define PBA_FL_TXD      1
`define PBA_FL_TXE      2
`define PBA_FL_ALLOC    3

////////////////////////////////////////////////////////////////////////////////
// host register word offsets and reset values
`define PBA_REG_CMD     4'h0
`define PBA_REG_CTRL    4'h1
`define PBA_REG_SEL     4'h2
`define PBA_REG_PTR     4'h3
`define PBA_REG_SAVE    4'h4
`define PBA_REG_STAT    4'h5
`define PBA_REG_QUE     4'h6
`define PBA_REG_PSTAT   4'h7
`define PBA_RST_RESERVE 8'h00
`define PBA_RST_MASK    4'h0

`endif

// ---- hdl/pba_pkg.sv ----
// types shared by both ends of the packet buffer allocator.
// assumes pba_consts.svh is on the include path.
`include "pba_consts.svh"
package pba_pkg;
	typedef logic [`PBA_PNUM_W-1:0] pba_pnum_t;   // packet number
	typedef logic [`PBA_PAGE_W-1:0] pba_pages_t;  // page count
	typedef logic [`PBA_STAT_W-1:0] pba_stat_t;   // completion status word
	typedef enum logic [2:0] {
		PBA_NOP   = `PBA_CMD_NOP,
		PBA_ALLOC = `PBA_CMD_ALLOC,
		PBA_ENQ   = `PBA_CMD_ENQ,
		PBA_REL   = `PBA_CMD_REL,
		PBA_RXPOP = `PBA_CMD_RXPOP,
		PBA_TXACK = `PBA_CMD_TXACK,
		PBA_TXEN  = `PBA_CMD_TXEN
	} pba_cmd_t;
endpackage

// ---- hdl/pba_if.sv ----
// link between the host controller and the buffer manager.
// assumes both ends run on the same clock; no clocking here.
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
interface pba_if;
	// host to manager
	logic                   cmd_valid;     // one-cycle command strobe
	pba_pkg::pba_cmd_t      cmd_code;      // command
	pba_pkg::pba_pages_t    cmd_arg;       // pages for an allocation
	pba_pkg::pba_pnum_t     pkt_sel;       // packet_select_reg value
	pba_pkg::pba_pages_t    reserve;       // pages held back for transmit
	logic                   auto_free;     // release good transmits at once
	logic [3:0]             irq_mask;      // per-flag interrupt enable
	// manager to host
	logic                   alloc_pending; // allocation still waiting
	pba_pkg::pba_pnum_t     alloc_pnum;    // number given by last allocation
	pba_pkg::pba_pages_t    free_pages;    // free pool, read only
	pba_pkg::pba_pages_t    total_pages;   // pool size, read only
	logic [3:0]             flags;         // raw event flags
	logic                   irq;           // masked interrupt
	logic                   tx_enable;     // transmit_enable_bit
	pba_pkg::pba_pnum_t     rx_head;       // head of received queue
	pba_pkg::pba_pnum_t     done_head;     // head of completion queue
	pba_pkg::pba_stat_t     pkt_status;    // status word of selected packet

	modport dev (
		input  cmd_valid, cmd_code, cmd_arg, pkt_sel, reserve, auto_free, irq_mask,
		output alloc_pending, alloc_pnum, free_pages, total_pages, flags, irq,
		output tx_enable, rx_head, done_head, pkt_status
	);
	modport host (
		output cmd_valid, cmd_code, cmd_arg, pkt_sel, reserve, auto_free, irq_mask,
		input  alloc_pending, alloc_pnum, free_pages, total_pages, flags, irq,
		input  tx_enable, rx_head, done_head, pkt_status
	);
endinterface
`default_nettype wire

// ---- hdl/pba_host.sv ----
// host controller: avalon-mm register slave that turns register writes into
// manager commands and holds packet select, pointer and their saved copies.
// assumes the manager on the link shares clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
module pba_host (
	input  wire logic        clk_sys_i,          // system clock
	input  wire logic        resetn_i,           // async reset, low
	input  wire logic [3:0]  avs_address_i,      // word address
	input  wire logic        avs_read_i,         // read request
	input  wire logic        avs_write_i,        // write request
	input  wire logic [31:0] avs_writedata_i,    // write data
	input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
	output logic [31:0]      avs_readdata_o,     // read data
	output logic             avs_waitrequest_o,  // stall
	output logic [`PBA_PTR_W-1:0] pointer_o,     // memory pointer for the data path
	pba_if.host              link                // to the manager
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic               ack_q;     // second cycle of an access
	logic [3:0]         irq_mask;  // interrupt enables
	logic               auto_free; // auto-free mode
	pba_pkg::pba_pages_t reserve;  // transmit reserve
	pba_pkg::pba_pnum_t pkt_sel;   // packet_select_reg
	pba_pkg::pba_pnum_t sv_sel;    // saved packet select
	logic [`PBA_PTR_W-1:0] pointer;  // shared pointer
	logic [`PBA_PTR_W-1:0] sv_ptr;   // saved pointer
	logic               cmd_valid; // command strobe
	pba_pkg::pba_cmd_t  cmd_code;  // command
	pba_pkg::pba_pages_t cmd_arg;  // command argument

	////////////////////////////////////////////////////////////////////////////
	// every access takes two edges: the first latches read data
	wire req   = avs_read_i || avs_write_i;
	wire take  = req && ack_q;
	wire wr    = take && avs_write_i;
	wire be0   = avs_byteenable_i[0];
	wire be1   = avs_byteenable_i[1];
	wire w_cmd  = wr && avs_address_i == `PBA_REG_CMD && be0;
	wire w_ctrl = wr && avs_address_i == `PBA_REG_CTRL;
	wire w_sel  = wr && avs_address_i == `PBA_REG_SEL && be0;
	wire w_ptr  = wr && avs_address_i == `PBA_REG_PTR;
	wire w_save = wr && avs_address_i == `PBA_REG_SAVE && be0;
	assign avs_waitrequest_o = req && !ack_q;

	// read selection; unmapped words read zero
	logic [31:0] rmux;
	always_comb begin
		case (avs_address_i)
			`PBA_REG_CMD:   rmux = {22'h0, link.alloc_pending, 5'h0, link.alloc_pnum};
			`PBA_REG_CTRL:  rmux = {16'h0, reserve, 3'h0, auto_free, irq_mask};
			`PBA_REG_SEL:   rmux = {28'h0, pkt_sel};
			`PBA_REG_PTR:   rmux = {21'h0, pointer};
			`PBA_REG_STAT:  rmux = {8'h0, link.total_pages, link.free_pages, 2'h0,
				link.tx_enable, link.irq, link.flags};
			`PBA_REG_QUE:   rmux = {19'h0, !link.flags[`PBA_FL_TXD], link.done_head,
				3'h0, !link.flags[`PBA_FL_RX], link.rx_head};
			`PBA_REG_PSTAT: rmux = {16'h0, link.pkt_status};
			default:        rmux = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// bus handshake and read data
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_q          <= 1'b0;
			avs_readdata_o <= 32'h0;
		end else begin
			ack_q <= req && !ack_q;
			if (avs_read_i && !ack_q) begin
				avs_readdata_o <= rmux;
			end
		end
	end

	// configuration, select, pointer and their save slots
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask  <= `PBA_RST_MASK;
			auto_free <= 1'b0;
			reserve   <= `PBA_RST_RESERVE;
			pkt_sel   <= '0;
			sv_sel    <= '0;
			pointer   <= '0;
			sv_ptr    <= '0;
		end else begin
			if (w_ctrl && be0) begin
				irq_mask  <= avs_writedata_i[3:0];                   // [RL14] [RL15]
				auto_free <= avs_writedata_i[4];                     // [RL14] [RL15]
			end
			if (w_ctrl && be1) begin
				reserve <= avs_writedata_i[15:8];
			end
			// restore beats a plain write so a return puts things back
			if (w_save && avs_writedata_i[1]) begin
				pkt_sel <= sv_sel;                                   // [RL18]
				pointer <= sv_ptr;                                   // [RL17]
			end else begin
				if (w_sel) begin
					pkt_sel <= avs_writedata_i[`PBA_PNUM_W-1:0];
				end
				if (w_ptr && be0 && be1) begin
					pointer <= avs_writedata_i[`PBA_PTR_W-1:0];
				end
			end
			if (w_save && avs_writedata_i[0]) begin
				sv_sel <= pkt_sel;                                   // [RL18]
				sv_ptr <= pointer;                                   // [RL17]
			end
		end
	end

	// command strobe, one cycle after the accepting edge
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_valid <= 1'b0;
			cmd_code  <= pba_pkg::PBA_NOP;
			cmd_arg   <= '0;
		end else begin
			cmd_valid <= w_cmd;
			if (w_cmd) begin
				cmd_code <= pba_pkg::pba_cmd_t'(avs_writedata_i[2:0]);
				cmd_arg  <= avs_writedata_i[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link drive
	assign link.cmd_valid = cmd_valid;
	assign link.cmd_code  = cmd_code;
	assign link.cmd_arg   = cmd_arg;
	assign link.pkt_sel   = pkt_sel;
	assign link.reserve   = reserve;
	assign link.auto_free = auto_free;
	assign link.irq_mask  = irq_mask;
	assign pointer_o      = pointer;

endmodule
`default_nettype wire

// ---- sim/pba_props.sv ----
// checker: link-level assertions between host controller and manager
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
module pba_props (
	input wire logic                clk_sys_i, resetn_i, cmd_valid, alloc_pending, irq, tx_enable,
	input wire pba_pkg::pba_cmd_t   cmd_code,
	input wire pba_pkg::pba_pages_t free_pages, total_pages,
	input wire logic [3:0]          flags, irq_mask
);
	default clocking dc @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// a fresh allocation; a second one while waiting may meet a grant
	wire alloc_go = cmd_valid && cmd_code == pba_pkg::PBA_ALLOC && !alloc_pending;
	////////////////////////////////////////////////////////////////////////////////
	irq_mask_a: assert property (irq == |(flags & irq_mask)) else $error("irq mismatch");
	pool_size_a: assert property (total_pages == `PBA_MEM_PAGES) else $error("size");
	free_cap_a: assert property (free_pages <= total_pages) else $error("free count");
	alloc_clr_a: assert property (alloc_go |=> alloc_pending && !flags[3]) else $error("clr");
	alloc_hold_a: assert property ($fell(flags[3]) |-> $past(cmd_valid && cmd_code == pba_pkg::PBA_ALLOC))
		else $error("alloc flag dropped");
	grant_done_a: assert property ($rose(flags[3]) |-> !alloc_pending) else $error("grant");
	txq_fill_a: assert property (cmd_valid && cmd_code == pba_pkg::PBA_ENQ |=> !flags[2])
		else $error("tx empty flag");
	txen_cause_a: assert property ($rose(tx_enable) |-> $past(cmd_valid && cmd_code == pba_pkg::PBA_TXEN))
		else $error("tx enable");
endmodule
`default_nettype wire

// ---- sim/test_packet_buffer_alloc_irq.sv ----
// bench: host over avalon-mm, network engine driven by hand, both ends joined
// assumes the design under hdl/ and pba_props beside the link
`timescale 1ns/100ps
`default_nettype none
`include "pba_consts.svh"
module test_packet_buffer_alloc_irq;
	logic        clk_sys_i = 0, resetn_i = 0, rd = 0, wr = 0, req = 0, rxd = 0, txd = 0, txok = 0;
	logic [3:0]  adr = 0, pn = 0;
	logic [31:0] wd = 0, rdat;
	wire  [31:0] rdo;
	wire         wq, ack, ok, txr;
	wire  [3:0]  apn, tpn;
	wire  [10:0] ptr;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	pba_if bus();
	pba_host pba_host_inst(.clk_sys_i, .resetn_i, .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
		.avs_waitrequest_o(wq), .pointer_o(ptr), .link(bus));
	pba_dev pba_dev_inst(.clk_sys_i, .resetn_i, .link(bus), .rx_alloc_req_i(req),
		.rx_alloc_pages_i(8'h02), .rx_alloc_ack_o(ack), .rx_alloc_ok_o(ok), .rx_alloc_pnum_o(apn),
		.rx_done_i(rxd), .rx_good_i(1'h1), .rx_pnum_i(pn), .rx_status_i(16'h0000),
		.tx_req_o(txr), .tx_pnum_o(tpn), .tx_done_i(txd), .tx_ok_i(txok),
		.tx_status_i({12'h0a0, pn}));
	pba_props pba_props_inst(.clk_sys_i, .resetn_i, .cmd_valid(bus.cmd_valid),
		.alloc_pending(bus.alloc_pending), .irq(bus.irq), .tx_enable(bus.tx_enable),
		.cmd_code(bus.cmd_code), .free_pages(bus.free_pages), .total_pages(bus.total_pages),
		.flags(bus.flags), .irq_mask(bus.irq_mask));
	////////////////////////////////////////////////////////////////////////////////
	initial forever #10 clk_sys_i = ~clk_sys_i;
	// hang guard, far above the roughly 130 cycles the run needs
	always @(posedge clk_sys_i) if (++cyc == 20000) begin
		n_mismatch++;
		close_out();
	end
	task automatic close_out();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one avalon access; waitrequest is judged settled mid-cycle, acted on at the edge
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do @(negedge clk_sys_i); while (wq !== 1'h0);
		@(posedge clk_sys_i);
		rdat = rdo;
		rd <= 0;
		wr <= 0;
		@(posedge clk_sys_i);
	endtask
	// engine allocation of two pages; number only meaningful on a grant
	task automatic eng(input logic [4:0] exp);
		req <= 1;
		do @(negedge clk_sys_i); while (ack !== 1'h1);
		chk({ok, apn & {4{ok}}}, exp);
		@(posedge clk_sys_i);
		req <= 0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_alloc();
		av(1, 4'h0, 32'h0401);
		repeat (10) begin
			av(0, 4'h0, 0);
			if (rdat[9] === 1'h0) break;
		end
		chk(rdat[9:0], 10'h000);
		av(0, 4'h5, 0);
		chk(rdat, 32'h0018_140c);
	endtask
	task automatic t_reserve();
		av(1, 4'h1, 32'h1401);
		eng(5'h00);
		av(1, 4'h1, 32'h1301);
		eng(5'h11);
		pn <= 1;
		rxd <= 1;
		@(posedge clk_sys_i);
		rxd <= 0;
		av(0, 4'h5, 0);
		chk(rdat[15:0], 16'h121d);
		av(1, 4'h0, 32'h0004);
		av(0, 4'h5, 0);
		chk(rdat[15:0], 16'h140c);
	endtask
	task automatic t_tx();
		av(1, 4'h2, 0);
		av(1, 4'h0, 32'h0002);
		av(1, 4'h0, 32'h0006);
		@(negedge clk_sys_i);
		chk({txr, tpn}, 5'h10);
		// the engine pulse is launched right after a rising edge
		@(posedge clk_sys_i);
		txd <= 1;
		@(posedge clk_sys_i);
		txd <= 0;
		av(0, 4'h6, 0);
		chk(rdat[12:8], 5'h00);
		av(0, 4'h5, 0);
		chk(rdat[5:0], 6'h0e);
		av(1, 4'h0, 32'h0005);
		av(1, 4'h0, 32'h0003);
		av(0, 4'h5, 0);
		chk(rdat[15:0], 16'h180c);
	endtask
	// interrupt save and restore, then the per-sequence and per-packet modes
	task automatic t_modes();
		av(1, 4'h3, 32'h0123);
		av(1, 4'h4, 32'h0001);
		av(1, 4'h2, 32'h0005);
		av(1, 4'h3, 32'h0456);
		av(1, 4'h4, 32'h0002);
		av(0, 4'h2, 0);
		chk({ptr, rdat[3:0]}, 15'h1230);
		av(1, 4'h1, 32'h0016);
		// first a good send that frees itself, then a fatal one that is kept
		for (int i = 0; i < 2; i++) begin
			av(1, 4'h0, 32'h0201);
			repeat (10) begin
				av(0, 4'h0, 0);
				if (rdat[9] === 1'h0) break;
			end
			av(1, 4'h0, 32'h0002);
			av(1, 4'h0, 32'h0006);
			txok <= (i == 0);
			txd <= 1;
			@(posedge clk_sys_i);
			txd <= 0;
			av(0, 4'h5, 0);
			chk(rdat[15:0], i ? 16'h161e : 16'h183c);
		end
		av(1, 4'h1, 32'h0002);
		av(0, 4'h7, 0);
		chk(rdat, 32'h0000_0a01);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1;
		@(posedge clk_sys_i);
		av(0, 4'h5, 0);
		chk(rdat, 32'h0018_1804);
		t_alloc();
		t_reserve();
		t_tx();
		t_modes();
		close_out();
	end
endmodule
`default_nettype wire
